// ===== serial_eeprom_read_and_ack_poll_tb.sv
`timescale 1ns/1ps
// =====================================================================
// Reads, pointer walk and write-cycle polling
module serial_eeprom_read_and_ack_poll_tb;
  import serp_pkg::*;
  localparam int         WR_N  = 1500;
  localparam logic [2:0] MY_CS = 3'h5;
  logic              ref_clk, link_clk, rst_n, ce, scl, sda_m, sda_i, sda_o, sda_oe_n, mem_rd_en, write_busy;
  logic [ADDR_W-1:0] mem_rd_addr;
  logic [DATA_W-1:0] mem_rd_data;
  logic [CS_W-1:0]   cs_pins;
  logic [31:0]       rng;
  int                error_cnt, check_count, ptr;
  logic [7:0]        exp_q[$];

  // =====================================================================
  // Clocks, wired-AND data line, memory
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end
  assign sda_i = sda_m & (sda_oe_n | sda_o);
  // Combinational so the byte is ready on the edge after the strobe
  assign mem_rd_data = mem_rd_addr[7:0] ^ mem_rd_addr[15:8] ^ 8'h3c;

  serp_top #(.WR_CYCLES(WR_N)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .link_clk(link_clk),
    .scl_i(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .chip_select_pins(cs_pins),
    .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .write_busy(write_busy));
  serp_master u_mst (.scl(scl), .sda_m(sda_m), .sda(sda_i));

  // =====================================================================
  // Model and compares
  function automatic logic [7:0] mdat(input int a);
    logic [15:0] w;
    w = a[15:0];
    return w[7:0] ^ w[15:8] ^ 8'h3c;
  endfunction

  function automatic logic [31:0] xnext(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_adr(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // =====================================================================
  // Bus sequences
  task automatic set_ptr(input logic [15:0] adr);
    logic a;
    u_mst.start();
    u_mst.wbyte({CTL_CODE, MY_CS, 1'b0}, a);
    chk_bit(a, 1'b1);
    u_mst.wbyte(adr[15:8], a);
    chk_bit(a, 1'b1);
    u_mst.wbyte(adr[7:0], a);
    chk_bit(a, 1'b1);
    ptr = adr;
  endtask

  task automatic rd_seq(input int n);
    logic       a;
    logic [7:0] d;
    u_mst.start();
    u_mst.wbyte({CTL_CODE, MY_CS, 1'b1}, a);
    chk_bit(a, 1'b1);
    for (int i = 0; i < n; i++) begin
      chk_adr(mem_rd_addr, ptr[15:0]);
      exp_q.push_back(mdat(ptr));
      u_mst.rbyte(i < n - 1, d);
      chk_byte(d, exp_q.pop_front());
      ptr = (ptr + 1) % 65536;
    end
    chk_bit(sda_oe_n, 1'b1);
    u_mst.stop();
  endtask

  initial begin
    #2400000;
    error_cnt++;
    $display("watchdog expired");
    wrap_up();
  end

  initial begin
    logic a;
    int   n;
    rst_n = 1'b0;
    ce = 1'b1;
    cs_pins = MY_CS;
    error_cnt = 0;
    check_count = 0;
    ptr = 0;
    rng = 32'h0000002e;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge ref_clk);
    u_mst.start();
    u_mst.wbyte({CTL_CODE, ~MY_CS, 1'b1}, a);
    chk_bit(a, 1'b0);
    u_mst.start();
    u_mst.wbyte({4'hb, MY_CS, 1'b1}, a);
    chk_bit(a, 1'b0);
    u_mst.stop();
    $display("test refusals done");
    set_ptr(16'h1234);
    rd_seq(1);
    repeat (40) @(posedge ref_clk);
    chk_bit(write_busy, 1'b0);
    rd_seq(1);
    $display("test random and current read done");
    set_ptr(16'hfffe);
    rd_seq(4);
    $display("test sequential wrap done");
    set_ptr(16'h0010);
    rng = xnext(rng);
    u_mst.wbyte(rng[7:0], a);
    chk_bit(a, 1'b1);
    u_mst.stop();
    ptr = 16'h0011;
    repeat (40) @(posedge ref_clk);
    chk_bit(write_busy, 1'b1);
    n = 0;
    do begin
      u_mst.start();
      u_mst.wbyte({CTL_CODE, MY_CS, 1'b0}, a);
      if (n == 0) begin
        chk_bit(a, 1'b0);
      end
      n++;
    end while (!a && n < 6);
    chk_bit(a, 1'b1);
    rd_seq(1);
    $display("test write polling done");
    for (int k = 0; k < 3; k++) begin
      rng = xnext(rng);
      set_ptr(rng[15:0]);
      rd_seq(2);
    end
    $display("test random addresses done");
    wrap_up();
  end
endmodule

// ===== serp_hs.sv
`timescale 1ns/1ps
// =====================================================================
// Toggle handshake: the word is held in domain a until domain b echoes
module serp_hs #(parameter int W = 8) (
  input  wire logic a_clk,
  input  wire logic a_rst_n,
  input  wire logic a_ce,
  input  wire logic b_clk,
  input  wire logic b_rst_n,
  input  wire logic b_ce,
  serp_hs_if.xfr    ch
);
  logic         tog_a_r;
  logic         tog_a_nxt;
  logic [W-1:0] dat_a_r;
  logic [W-1:0] dat_a_nxt;
  logic         seen_r;
  logic         seen_nxt;
  logic         vld_b_r;
  logic         vld_b_nxt;
  logic [W-1:0] dat_b_r;
  logic [W-1:0] dat_b_nxt;
  logic         req_s;
  logic         ack_s;

  serp_sync #(.W(1)) u_req (.clk(b_clk), .en(b_ce), .d(tog_a_r), .q(req_s));
  serp_sync #(.W(1)) u_ack (.clk(a_clk), .en(a_ce), .d(seen_r), .q(ack_s));

  assign ch.busy = tog_a_r ^ ack_s;
  assign ch.ovld = vld_b_r;
  assign ch.odat = dat_b_r;

  always_comb begin
    tog_a_nxt = tog_a_r;
    dat_a_nxt = dat_a_r;
    if (ch.vld && !ch.busy) begin
      tog_a_nxt = ~tog_a_r;
      dat_a_nxt = ch.dat;
    end
  end

  always_ff @(posedge a_clk) begin
    if (!a_rst_n) begin
      tog_a_r <= 1'b0;
      dat_a_r <= '0;
    end else if (a_ce) begin
      tog_a_r <= tog_a_nxt;
      dat_a_r <= dat_a_nxt;
    end
  end

  // Data is stable here: the source holds it until the echo returns
  always_comb begin
    seen_nxt  = seen_r;
    vld_b_nxt = 1'b0;
    dat_b_nxt = dat_b_r;
    if (req_s != seen_r) begin
      seen_nxt  = req_s;
      vld_b_nxt = 1'b1;
      dat_b_nxt = dat_a_r;
    end
  end

  always_ff @(posedge b_clk) begin
    if (!b_rst_n) begin
      seen_r  <= 1'b0;
      vld_b_r <= 1'b0;
      dat_b_r <= '0;
    end else if (b_ce) begin
      seen_r  <= seen_nxt;
      vld_b_r <= vld_b_nxt;
      dat_b_r <= dat_b_nxt;
    end
  end
endmodule

// ===== serp_hs_if.sv
`timescale 1ns/1ps
// =====================================================================
// Word crossing channel between two clock domains
interface serp_hs_if #(parameter int W = 8);
  logic         vld;
  logic [W-1:0] dat;
  logic         busy;
  logic         ovld;
  logic [W-1:0] odat;
  modport usr (output vld, output dat, input busy, input ovld, input odat);
  modport xfr (input vld, input dat, output busy, output ovld, output odat);
endinterface

// ===== serp_master.sv
`timescale 1ns/1ps
// =====================================================================
// Bus master; its clock idles high between frames
module serp_master #(
  parameter int HALF_NS = 1200
) (
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  // Data moves a quarter into the low phase so it never races the falling clock
  task automatic xbit(input logic v, output logic s);
    #(HALF_NS / 4) sda_m = v;
    #(HALF_NS * 3 / 4) scl = 1'b1;
    #(HALF_NS / 2) s = sda;
    #(HALF_NS / 2) scl = 1'b0;
  endtask

  task automatic start();
    #(HALF_NS / 4) sda_m = 1'b1;
    #(HALF_NS * 3 / 4) scl = 1'b1;
    #(HALF_NS) sda_m = 1'b0;
    #(HALF_NS) scl = 1'b0;
  endtask

  task automatic stop();
    #(HALF_NS / 4) sda_m = 1'b0;
    #(HALF_NS * 3 / 4) scl = 1'b1;
    #(HALF_NS) sda_m = 1'b1;
    #(HALF_NS);
  endtask

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xbit(b[i], s);
    end
    xbit(1'b1, s);
    ack = !s;
  endtask

  task automatic rbyte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, s);
      b[i] = s;
    end
    xbit(!ack, s);
  endtask
endmodule

// ===== serp_pkg.sv
// =====================================================================
// Shared constants
package serp_pkg;

  localparam int          ADDR_W       = 16;
  localparam int          DATA_W       = 8;
  localparam int          CS_W         = 3;
  localparam int          MSG_W        = ADDR_W + 1;
  localparam int          PAGE_MSB     = 6;

  localparam logic [3:0]  CTL_CODE     = 4'ha;
  localparam logic [15:0] PTR_RST      = 16'h0000;
  localparam logic [3:0]  BITS_IN_BYTE = 4'h8;
  localparam logic [3:0]  TX_LAST_BIT  = 4'h7;
  localparam logic [1:0]  IDX_CTRL     = 2'h0;
  localparam logic [1:0]  IDX_ADR_HI   = 2'h1;
  localparam logic [1:0]  IDX_ADR_LO   = 2'h2;
  localparam logic [1:0]  IDX_DATA     = 2'h3;

  // Message kind bit carried from the link side to the core side
  localparam int          MSG_KIND_BIT = ADDR_W;
  localparam logic        MSG_RD       = 1'b0;
  localparam logic        MSG_WSTART   = 1'b1;

  // Internal write cycle time, microseconds, and its count at ref_clk
  localparam int          REF_CLK_MHZ  = 40;
  localparam int          WR_CYC_US    = 1000;
  localparam int          WR_CYC_CNT   = WR_CYC_US * REF_CLK_MHZ;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX   = 3'h1,
    ST_RACK = 3'h3,
    ST_HOLD = 3'h2,
    ST_TX   = 3'h6,
    ST_TACK = 3'h7,
    ST_SKIP = 3'h5
  } serp_st_e;

endpackage

// ===== serp_sync.sv
`timescale 1ns/1ps
// =====================================================================
// Two-stage synchroniser, one chain per bit
module serp_sync #(parameter int W = 1) (
  input  wire logic         clk,
  input  wire logic         en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      always_ff @(posedge clk) begin
        if (en) begin
          meta_r[gi] <= d[gi];
          q[gi]      <= meta_r[gi];
        end
      end
    end
  endgenerate
endmodule

// ===== serp_top.sv
`timescale 1ns/1ps
module serp_top
  import serp_pkg::*;
#(
  parameter int WR_CYCLES = WR_CYC_CNT
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic                ce,
  input  wire logic                link_clk,
  input  wire logic                scl_i,
  input  wire logic                sda_i,
  output logic                     sda_o,
  output logic                     sda_oe_n,
  input  wire logic [CS_W-1:0]     chip_select_pins,
  output logic                     mem_rd_en,
  output logic      [ADDR_W-1:0]   mem_rd_addr,
  input  wire logic [DATA_W-1:0]   mem_rd_data,
  output logic                     write_busy
);

  // ===================================================================
  // Decoding shared by the acknowledge decision
  function automatic logic ctl_match(input logic [7:0] b, input logic [CS_W-1:0] cs);
    ctl_match = (b[7:4] == CTL_CODE) && (b[3:1] == cs);
  endfunction

  // ===================================================================
  // Crossings
  serp_hs_if #(.W(MSG_W))  req_ch ();
  serp_hs_if #(.W(DATA_W)) rep_ch ();

  logic              scl_s;
  logic              sda_s;
  logic [CS_W-1:0]   cs_s;
  logic              lrst_n;
  logic              lce;
  logic              busy_s;

  // Pins, reset, enable and the busy level all enter the link domain here
  serp_sync #(.W(CS_W + 5)) u_lsync (
    .clk (link_clk),
    .en  (1'b1),
    .d   ({write_busy, ce, rst_n, chip_select_pins, sda_i, scl_i}),
    .q   ({busy_s, lce, lrst_n, cs_s, sda_s, scl_s})
  );

  serp_hs #(.W(MSG_W)) u_req (
    .a_clk   (link_clk),
    .a_rst_n (lrst_n),
    .a_ce    (lce),
    .b_clk   (ref_clk),
    .b_rst_n (rst_n),
    .b_ce    (ce),
    .ch      (req_ch.xfr)
  );

  serp_hs #(.W(DATA_W)) u_rep (
    .a_clk   (ref_clk),
    .a_rst_n (rst_n),
    .a_ce    (ce),
    .b_clk   (link_clk),
    .b_rst_n (lrst_n),
    .b_ce    (lce),
    .ch      (rep_ch.xfr)
  );

  // ===================================================================
  // Link side bus engine
  serp_st_e          st_r, st_nxt;
  logic [3:0]        bit_r, bit_nxt;
  logic [1:0]        idx_r, idx_nxt;
  logic [7:0]        sh_r, sh_nxt;
  logic [7:0]        tx_r, tx_nxt;
  logic [ADDR_W-1:0] ptr_r, ptr_nxt;
  logic [7:0]        ahi_r, ahi_nxt;
  logic              rw_r, rw_nxt;
  logic              wrp_r, wrp_nxt;
  logic              dok_r, dok_nxt;
  logic              oe_n_r, oe_n_nxt;
  logic              sdo_r;
  logic              scl_q_r, sda_q_r;
  logic              rq_vld_r, rq_vld_nxt;
  logic [MSG_W-1:0]  rq_dat_r, rq_dat_nxt;
  logic              rise, fall, start_c, stop_c;

  assign req_ch.vld = rq_vld_r;
  assign req_ch.dat = rq_dat_r;
  assign sda_oe_n   = oe_n_r;
  assign sda_o      = sdo_r;

  assign rise    = scl_s & ~scl_q_r;
  assign fall    = ~scl_s & scl_q_r;
  assign start_c = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop_c  = scl_s & scl_q_r & ~sda_q_r & sda_s;

  always_comb begin
    st_nxt     = st_r;
    bit_nxt    = bit_r;
    idx_nxt    = idx_r;
    sh_nxt     = sh_r;
    tx_nxt     = tx_r;
    ptr_nxt    = ptr_r;
    ahi_nxt    = ahi_r;
    rw_nxt     = rw_r;
    wrp_nxt    = wrp_r;
    dok_nxt    = dok_r;
    oe_n_nxt   = oe_n_r;
    // Hold a request while the crossing is still busy, so none is lost
    rq_vld_nxt = rq_vld_r & req_ch.busy;
    rq_dat_nxt = rq_dat_r;
    if (rep_ch.ovld) begin
      tx_nxt  = rep_ch.odat;
      dok_nxt = 1'b1;
    end
    if (start_c) begin
      st_nxt   = ST_RX;
      bit_nxt  = 4'h0;
      idx_nxt  = IDX_CTRL;
      wrp_nxt  = 1'b0;
      oe_n_nxt = 1'b1;
    end else if (stop_c) begin
      st_nxt   = ST_IDLE;
      oe_n_nxt = 1'b1;
      wrp_nxt  = 1'b0;
      if (wrp_r) begin
        rq_vld_nxt = 1'b1;
        rq_dat_nxt = {MSG_WSTART, ptr_r};
      end
    end else begin
      unique case (st_r)
        ST_IDLE, ST_SKIP: begin
          oe_n_nxt = 1'b1;
        end
        ST_RX: begin
          if (rise && bit_r != BITS_IN_BYTE) begin
            sh_nxt  = {sh_r[6:0], sda_s};
            bit_nxt = bit_r + 4'h1;
          end else if (fall && bit_r == BITS_IN_BYTE) begin
            oe_n_nxt = 1'b0;
            st_nxt   = ST_RACK;
            unique case (idx_r)
              IDX_CTRL: begin
                if (!ctl_match(sh_r, cs_s) || busy_s) begin
                  oe_n_nxt = 1'b1;
                  st_nxt   = ST_SKIP;
                end else begin
                  rw_nxt = sh_r[0];
                  if (sh_r[0]) begin
                    rq_vld_nxt = 1'b1;
                    rq_dat_nxt = {MSG_RD, ptr_r};
                    dok_nxt    = 1'b0;
                  end
                end
              end
              IDX_ADR_HI: begin
                ahi_nxt = sh_r;
              end
              IDX_ADR_LO: begin
                ptr_nxt = {ahi_r, sh_r};
              end
              IDX_DATA: begin
                wrp_nxt = 1'b1;
                ptr_nxt = {ptr_r[ADDR_W-1:PAGE_MSB+1], 7'(ptr_r[PAGE_MSB:0] + 7'h01)};
              end
            endcase
          end
        end
        ST_RACK: begin
          if (fall) begin
            oe_n_nxt = 1'b1;
            if (rw_r && idx_r == IDX_CTRL) begin
              st_nxt = ST_HOLD;
            end else begin
              st_nxt  = ST_RX;
              bit_nxt = 4'h0;
              idx_nxt = (idx_r == IDX_DATA) ? IDX_DATA : idx_r + 2'h1;
            end
          end
        end
        ST_HOLD: begin
          // Never change the line while the clock is high
          if (dok_r && !scl_s) begin
            st_nxt   = ST_TX;
            bit_nxt  = 4'h0;
            dok_nxt  = 1'b0;
            oe_n_nxt = tx_r[7];
          end
        end
        ST_TX: begin
          if (fall) begin
            if (bit_r == TX_LAST_BIT) begin
              oe_n_nxt = 1'b1;
              st_nxt   = ST_TACK;
            end else begin
              tx_nxt   = {tx_r[6:0], 1'b0};
              oe_n_nxt = tx_r[6];
              bit_nxt  = bit_r + 4'h1;
            end
          end
        end
        ST_TACK: begin
          if (rise) begin
            ptr_nxt = ptr_r + 16'h0001;
            if (!sda_s) begin
              rq_vld_nxt = 1'b1;
              rq_dat_nxt = {MSG_RD, ptr_r + 16'h0001};
              st_nxt     = ST_HOLD;
            end else begin
              st_nxt = ST_SKIP;
            end
          end
        end
        default: begin
          st_nxt   = ST_IDLE;
          oe_n_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      st_r     <= ST_IDLE;
      bit_r    <= 4'h0;
      idx_r    <= IDX_CTRL;
      sh_r     <= 8'h00;
      tx_r     <= 8'h00;
      ptr_r    <= PTR_RST;
      ahi_r    <= 8'h00;
      rw_r     <= 1'b0;
      wrp_r    <= 1'b0;
      dok_r    <= 1'b0;
      oe_n_r   <= 1'b1;
      sdo_r    <= 1'b0;
      scl_q_r  <= 1'b1;
      sda_q_r  <= 1'b1;
      rq_vld_r <= 1'b0;
      rq_dat_r <= '0;
    end else if (lce) begin
      st_r     <= st_nxt;
      bit_r    <= bit_nxt;
      idx_r    <= idx_nxt;
      sh_r     <= sh_nxt;
      tx_r     <= tx_nxt;
      ptr_r    <= ptr_nxt;
      ahi_r    <= ahi_nxt;
      rw_r     <= rw_nxt;
      wrp_r    <= wrp_nxt;
      dok_r    <= dok_nxt;
      oe_n_r   <= oe_n_nxt;
      sdo_r    <= 1'b0;
      scl_q_r  <= scl_s;
      sda_q_r  <= sda_s;
      rq_vld_r <= rq_vld_nxt;
      rq_dat_r <= rq_dat_nxt;
    end
  end

  // ===================================================================
  // Core side: memory fetch and write cycle timer
  logic              busy_r, busy_nxt;
  logic [31:0]       wcnt_r, wcnt_nxt;
  logic              rd_en_r, rd_en_nxt;
  logic [ADDR_W-1:0] rd_addr_r, rd_addr_nxt;
  logic              rd_pend_r;
  logic              rp_vld_r, rp_vld_nxt;
  logic [DATA_W-1:0] rp_dat_r, rp_dat_nxt;

  assign rep_ch.vld  = rp_vld_r;
  assign rep_ch.dat  = rp_dat_r;
  assign mem_rd_en   = rd_en_r;
  assign mem_rd_addr = rd_addr_r;
  assign write_busy  = busy_r;

  always_comb begin
    busy_nxt    = busy_r;
    wcnt_nxt    = wcnt_r;
    rd_en_nxt   = 1'b0;
    rd_addr_nxt = rd_addr_r;
    rp_vld_nxt  = rp_vld_r & rep_ch.busy;
    rp_dat_nxt  = rp_dat_r;
    if (req_ch.ovld && req_ch.odat[MSG_KIND_BIT] == MSG_WSTART) begin
      busy_nxt = 1'b1;
      wcnt_nxt = 32'(WR_CYCLES - 1);
    end else if (busy_r) begin
      if (wcnt_r == 32'h0000_0000) begin
        busy_nxt = 1'b0;
      end else begin
        wcnt_nxt = wcnt_r - 32'h0000_0001;
      end
    end
    if (req_ch.ovld && req_ch.odat[MSG_KIND_BIT] == MSG_RD) begin
      rd_en_nxt   = 1'b1;
      rd_addr_nxt = req_ch.odat[ADDR_W-1:0];
    end
    // Memory answers one cycle after the enable
    if (rd_pend_r) begin
      rp_vld_nxt = 1'b1;
      rp_dat_nxt = mem_rd_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busy_r    <= 1'b0;
      wcnt_r    <= 32'h0000_0000;
      rd_en_r   <= 1'b0;
      rd_addr_r <= PTR_RST;
      rd_pend_r <= 1'b0;
      rp_vld_r  <= 1'b0;
      rp_dat_r  <= 8'h00;
    end else if (ce) begin
      busy_r    <= busy_nxt;
      wcnt_r    <= wcnt_nxt;
      rd_en_r   <= rd_en_nxt;
      rd_addr_r <= rd_addr_nxt;
      rd_pend_r <= rd_en_r;
      rp_vld_r  <= rp_vld_nxt;
      rp_dat_r  <= rp_dat_nxt;
    end
  end

endmodule

// ===== serp_top_properties.sv
`timescale 1ns/1ps
// =====================================================================
// Port-level checks on the serial memory slave
module serp_top_props
  import serp_pkg::*;
#(
  parameter int WR_CYCLES = WR_CYC_CNT
) (
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic              ce,
  input wire logic              link_clk,
  input wire logic              scl_i,
  input wire logic              sda_i,
  input wire logic              sda_o,
  input wire logic              sda_oe_n,
  input wire logic [CS_W-1:0]   chip_select_pins,
  input wire logic              mem_rd_en,
  input wire logic [ADDR_W-1:0] mem_rd_addr,
  input wire logic [DATA_W-1:0] mem_rd_data,
  input wire logic              write_busy
);
  int         busy_cnt_r;
  logic [7:0] since_stop_r;
  logic       sda_d_r;

  // Counts only enabled cycles, as the timer freezes with the enable
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !write_busy) begin
      busy_cnt_r <= 0;
    end else if (ce) begin
      busy_cnt_r <= busy_cnt_r + 1;
    end
  end

  // Raw bus view, so a late start of the write cycle is caught against the real Stop
  always_ff @(posedge link_clk) begin
    sda_d_r <= sda_i;
    if (!rst_n) begin
      since_stop_r <= 8'hff;
    end else if (scl_i && sda_i && !sda_d_r) begin
      since_stop_r <= 8'h00;
    end else if (since_stop_r != 8'hff) begin
      since_stop_r <= since_stop_r + 8'h01;
    end
  end

  AST_RESET_VALS: assert property (@(posedge ref_clk) !rst_n |=> !write_busy && !mem_rd_en && mem_rd_addr == PTR_RST)
    else $error("outputs not at rest after reset");
  AST_BUSY_LEN: assert property (@(posedge ref_clk) disable iff (!rst_n) $fell(write_busy) |-> busy_cnt_r == WR_CYCLES)
    else $error("write cycle length wrong");
  AST_BUSY_START: assert property (@(posedge ref_clk) disable iff (!rst_n) $rose(write_busy) |-> since_stop_r < 8'h14)
    else $error("write cycle began without a recent Stop");
  AST_BUSY_NOACK: assert property (@(posedge ref_clk) disable iff (!rst_n) write_busy |-> sda_oe_n)
    else $error("data line driven during write cycle");
  AST_SDA_O_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n) sda_o == 1'b0)
    else $error("data output not low");
  AST_RD_PULSE: assert property (@(posedge ref_clk) disable iff (!rst_n) mem_rd_en |=> !mem_rd_en [*8])
    else $error("memory read strobe too long or too close");
  AST_RD_ADDR_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n) $changed(mem_rd_addr) |-> mem_rd_en)
    else $error("read address moved without a read");
  AST_DRIVE_SCL_LOW: assert property (@(posedge link_clk) disable iff (!rst_n) $changed(sda_oe_n) |-> !scl_i)
    else $error("data line changed while clock high");
endmodule

bind serp_top serp_top_props #(.WR_CYCLES(WR_CYCLES)) u_props (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
  .link_clk(link_clk), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
  .chip_select_pins(chip_select_pins), .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr),
  .mem_rd_data(mem_rd_data), .write_busy(write_busy));
